// file: rtl/auto_buffer_serial_transfer.sv
// Purpose: Automatic buffer-RAM serial transfer engine with Wishbone access.
// Assumes: Serial clock comes from the partner and idles high.
// Notes: All pin inputs pass a two-stage synchroniser before use.
// Function
// - Received byte stored at counter address, counter increments.
// - Counter equals pointer: stop, flag, clear counter/busy.
// - Transmit-only sends bytes without storing received data.
// - Start needs enable, auto mode, transmit enable; the code also starts with receive enable alone.
// - Transmit-only sets flag after last byte, busy clears.
// - Serial input pin released when reception unused.
// - Interval register spaces bytes; collisions may lengthen it.
// - Repeat start also needs repeat mode bit.
// - Repeat end: no flag, counter zero, resend.
// - Output data changes on serial clock falling edge; the code drives the first bit of each byte at load instead.
// - Eight-bit units, order bit selects MSB/LSB first.
// - Software writes suspend bit to suspend transfer.
// - Suspend waits for current byte to complete.
// - Suspension clears busy after the eighth bit.
// - Halt pauses between bytes, release resumes.
// - Input sampled on serial clock rising edge.
// - Disable ends silently; other endings raise flag.
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module auto_buffer_serial_transfer
    import auto_xfer_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Wishbone classic slave.
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [3:0] wbSel,
    input wire logic [auto_xfer_pkg::ADR_W-1:0] wbAdr,
    input wire logic [auto_xfer_pkg::DAT_W-1:0] wbDatIn,
    output logic [auto_xfer_pkg::DAT_W-1:0] wbDatOut,
    output logic wbAck,
    // Serial link pins.
    input wire logic serialClockPin,
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutOe,
    output logic portPinAltRelease,
    // Processor and status.
    input wire logic cpuHalt,
    output logic xferDoneIrq,
    output logic xferInProgress
);
    import auto_xfer_pkg::*;

    // Buffer RAM, one byte per word slot.
    logic [BYTE_W-1:0] bufRam [RAM_DEPTH];

    // Software-visible registers; the pending-suspend flag is internal.
    serial_mode_t serialMode_reg; // Mode and enable bits.
    logic [RAM_AW-1:0] xferEndPointer_reg; // Index of the last byte.
    logic [BYTE_W-1:0] xferInterval_reg; // Gap length in core cycles.
    logic [RAM_AW-1:0] xferAddrCounter_reg; // Current buffer index.
    logic xferDoneFlag_reg; // Sticky completion flag.
    logic busy_reg; // Transfer in progress.
    logic suspendPending_reg; // Suspend request waiting for byte end.

    // Engine state.
    xfer_state_t state_reg;
    logic [BYTE_W-1:0] shift_reg; // Serial shift register.
    logic [3:0] bitCnt_reg; // Bits taken in this byte.
    logic [BYTE_W-1:0] gapCnt_reg; // Interval counter.

    // Synchronisers and edge finder for the link pins.
    logic sclkMeta_reg, sclkSync_reg, sclkPrev_reg;
    logic sinMeta_reg, sinSync_reg;

    // Output flops.
    logic ack_reg;
    logic [DAT_W-1:0] rdData_reg;
    logic sout_reg, soutOe_reg, release_reg, irq_reg;

    // Decoded bus, link-edge and engine terms.
    logic busReq, busWrite, ramSel, cpuRamReq, engGrant;
    logic [RAM_AW-1:0] ramIdx;
    logic startReq, suspendReq, clearDone;
    logic sclkRise, sclkFall, startOk, lastByte, doneSet;

    // Decode a request once per cycle; the write lands on the ack edge.
    assign busReq = wbCyc && wbStb && !ack_reg;
    assign busWrite = busReq && wbWe && wbSel[0];
    assign ramSel = wbAdr[RAM_SEL_BIT];
    assign ramIdx = wbAdr[RAM_IDX_LSB +: RAM_AW];
    // The CPU owns the buffer port whenever it addresses it.
    assign cpuRamReq = wbCyc && wbStb && ramSel;
    assign engGrant = !cpuRamReq;
    assign startReq = busWrite && !ramSel && (wbAdr == OFS_TRIGGER)
                      && wbDatIn[TRIG_START_BIT];
    assign suspendReq = busWrite && !ramSel && (wbAdr == OFS_TRIGGER)
                        && wbDatIn[TRIG_SUSPEND_BIT];
    assign clearDone = busWrite && !ramSel && (wbAdr == OFS_STATUS)
                       && wbDatIn[STAT_DONE_BIT];
    // Both auto modes need enable and auto bit; repeat needs transmit too.
    assign startOk = serialMode_reg.ifaceEnable
                     && serialMode_reg.autoModeEnable
                     && (serialMode_reg.txEnable || serialMode_reg.rxEnable)
                     && (!serialMode_reg.repeatMode
                         || serialMode_reg.txEnable);
    assign sclkRise = sclkSync_reg && !sclkPrev_reg;
    assign sclkFall = !sclkSync_reg && sclkPrev_reg;
    assign lastByte = (xferAddrCounter_reg == xferEndPointer_reg);
    // A byte that ends the block or a suspension raises the flag.
    assign doneSet = (state_reg == ST_STORE) && engGrant
                     && serialMode_reg.ifaceEnable
                     && ((lastByte && !serialMode_reg.repeatMode)
                         || suspendPending_reg);

    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sclkMeta_reg <= 1'b1;
            sclkSync_reg <= 1'b1;
            sclkPrev_reg <= 1'b1;
            sinMeta_reg <= 1'b0;
            sinSync_reg <= 1'b0;
        end else begin
            sclkMeta_reg <= serialClockPin;
            sclkSync_reg <= sclkMeta_reg;
            sclkPrev_reg <= sclkSync_reg;
            sinMeta_reg <= serialInPin;
            sinSync_reg <= sinMeta_reg;
        end
    end

    // Wishbone answer: one ack per request, data registered with it.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            rdData_reg <= '0;
        end else begin
            ack_reg <= busReq;
            rdData_reg <= '0;
            if (busReq && ramSel) begin
                rdData_reg[BYTE_W-1:0] <= bufRam[ramIdx];
            end else if (busReq) begin
                case (wbAdr)
                    OFS_MODE: rdData_reg[BYTE_W-1:0] <= serialMode_reg;
                    OFS_STATUS: begin
                        rdData_reg[STAT_BUSY_BIT] <= busy_reg;
                        rdData_reg[STAT_DONE_BIT] <= xferDoneFlag_reg;
                    end
                    OFS_END_PTR: rdData_reg[RAM_AW-1:0] <= xferEndPointer_reg;
                    OFS_ADDR_CNT: begin
                        rdData_reg[RAM_AW-1:0] <= xferAddrCounter_reg;
                    end
                    OFS_INTERVAL: rdData_reg[BYTE_W-1:0] <= xferInterval_reg;
                    // Trigger and unmapped words read as zero.
                    default: rdData_reg <= '0;
                endcase
            end
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serialMode_reg <= MODE_RESET;
            xferEndPointer_reg <= ADDR_RESET;
            xferInterval_reg <= INTERVAL_RESET;
        end else if (busWrite && !ramSel) begin
            case (wbAdr)
                OFS_MODE: serialMode_reg <= wbDatIn[BYTE_W-1:0];
                OFS_END_PTR: xferEndPointer_reg <= wbDatIn[RAM_AW-1:0];
                OFS_INTERVAL: xferInterval_reg <= wbDatIn[BYTE_W-1:0];
                // Other offsets hold no configuration.
                default: xferInterval_reg <= xferInterval_reg;
            endcase
        end
    end

    // Buffer RAM port: the CPU is served first, the engine otherwise.
    always_ff @(posedge core_clk) begin
        if (busWrite && ramSel) begin
            bufRam[ramIdx] <= wbDatIn[BYTE_W-1:0];
        end else if (state_reg == ST_STORE && engGrant
                     && serialMode_reg.rxEnable) begin
            bufRam[xferAddrCounter_reg] <= shift_reg;
        end
    end

    // Transfer sequencer: load, shift, store, gap.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            xferAddrCounter_reg <= ADDR_RESET;
            busy_reg <= 1'b0;
            suspendPending_reg <= 1'b0;
            shift_reg <= '0;
            bitCnt_reg <= '0;
            gapCnt_reg <= '0;
        end else if (!serialMode_reg.ifaceEnable) begin
            // Stop without a flag and clear the counter.
            state_reg <= ST_IDLE;
            xferAddrCounter_reg <= ADDR_RESET;
            busy_reg <= 1'b0;
            suspendPending_reg <= 1'b0;
        end else begin
            // A suspend only takes effect at the next byte end.
            if (suspendReq && busy_reg) begin
                suspendPending_reg <= 1'b1;
            end
            case (state_reg)
                ST_IDLE: begin
                    suspendPending_reg <= 1'b0;
                    if (startReq && startOk) begin
                        busy_reg <= 1'b1;
                        state_reg <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // Halt and CPU traffic hold the engine between bytes.
                    if (engGrant && !cpuHalt) begin
                        shift_reg <= bufRam[xferAddrCounter_reg];
                        bitCnt_reg <= '0;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (sclkRise) begin
                        shift_reg <= shiftIn(shift_reg,
                            serialMode_reg.bitOrderLsb, sinSync_reg);
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end
                    if (bitCnt_reg == BITS_PER_UNIT) begin
                        state_reg <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    // Transmit-only skips the write but keeps the order.
                    if (engGrant) begin
                        gapCnt_reg <= xferInterval_reg;
                        if (lastByte && !serialMode_reg.repeatMode) begin
                            xferAddrCounter_reg <= ADDR_RESET;
                            busy_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else if (suspendPending_reg) begin
                            busy_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                            if (!lastByte) begin
                                xferAddrCounter_reg <=
                                    xferAddrCounter_reg + 5'h01;
                            end else begin
                                xferAddrCounter_reg <= ADDR_RESET;
                            end
                        end else if (lastByte) begin
                            xferAddrCounter_reg <= ADDR_RESET;
                            state_reg <= ST_GAP;
                        end else begin
                            xferAddrCounter_reg <=
                                xferAddrCounter_reg + 5'h01;
                            state_reg <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    // The interval stretches while the CPU holds the buffer.
                    if (!cpuHalt && engGrant) begin
                        if (gapCnt_reg == '0) begin
                            state_reg <= ST_LOAD;
                        end else begin
                            gapCnt_reg <= gapCnt_reg - 8'h01;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Sticky completion flag; a set in the clearing cycle wins.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            xferDoneFlag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= doneSet;
            if (doneSet) begin
                xferDoneFlag_reg <= 1'b1;
            end else if (clearDone) begin
                xferDoneFlag_reg <= 1'b0;
            end
        end
    end

    // Serial output: first bit at load, later bits on falling edges.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sout_reg <= 1'b1;
            soutOe_reg <= 1'b0;
            release_reg <= 1'b1;
        end else begin
            soutOe_reg <= serialMode_reg.ifaceEnable
                          && serialMode_reg.txEnable;
            // Without reception the input pin is free for port use.
            release_reg <= !(serialMode_reg.ifaceEnable
                             && serialMode_reg.rxEnable);
            if (state_reg == ST_LOAD && engGrant && !cpuHalt) begin
                sout_reg <= outBit(bufRam[xferAddrCounter_reg],
                                   serialMode_reg.bitOrderLsb);
            end else if (state_reg == ST_SHIFT && sclkFall
                         && bitCnt_reg != '0
                         && bitCnt_reg != BITS_PER_UNIT) begin
                sout_reg <= outBit(shift_reg,
                                   serialMode_reg.bitOrderLsb);
            end
        end
    end

    // Top-level outputs straight from flops.
    assign wbAck = ack_reg;
    assign wbDatOut = rdData_reg;
    assign serialOutPin = sout_reg;
    assign serialOutOe = soutOe_reg;
    assign portPinAltRelease = release_reg;
    assign xferDoneIrq = irq_reg;
    assign xferInProgress = busy_reg;

    // Checks on the engine's behaviour.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    storeWrite_a: assert property ((state_reg == ST_STORE) && engGrant
        && serialMode_reg.rxEnable && serialMode_reg.ifaceEnable
        |=> bufRam[$past(xferAddrCounter_reg)] == $past(shift_reg))
        else $error("Received byte not stored at counter address.");
    endClear_a: assert property (doneSet && lastByte
        |=> (xferAddrCounter_reg == ADDR_RESET) && !busy_reg
            && xferDoneFlag_reg && xferDoneIrq)
        else $error("Block end did not clear counter and raise flag.");
    startCond_a: assert property ($rose(busy_reg)
        |-> $past(serialMode_reg.autoModeEnable && startReq))
        else $error("Transfer started without its enables.");
    repeatNoFlag_a: assert property ((state_reg == ST_STORE)
        && engGrant && lastByte && serialMode_reg.repeatMode
        && !suspendPending_reg && serialMode_reg.ifaceEnable
        |=> (xferAddrCounter_reg == ADDR_RESET) && busy_reg
            && !xferDoneIrq ##1 (state_reg == ST_GAP || state_reg == ST_LOAD))
        else $error("Repeat mode flagged or failed to wrap.");
    fallChange_a: assert property ($changed(sout_reg)
        |-> $past(sclkFall || state_reg == ST_LOAD))
        else $error("Serial output changed off a falling edge.");
    byteHold_a: assert property ((state_reg == ST_SHIFT)
        && serialMode_reg.ifaceEnable |=> busy_reg)
        else $error("Transfer ended in the middle of a byte.");
    suspendEnd_a: assert property ((state_reg == ST_STORE)
        && engGrant && suspendPending_reg && serialMode_reg.ifaceEnable
        |=> !busy_reg && xferDoneFlag_reg)
        else $error("Suspension did not clear busy at byte end.");
    haltHold_a: assert property ((state_reg == ST_LOAD) && cpuHalt
        && serialMode_reg.ifaceEnable |=> state_reg == ST_LOAD)
        else $error("Engine left the byte boundary during halt.");
    abortQuiet_a: assert property (busy_reg
        && !serialMode_reg.ifaceEnable |=> !busy_reg ##1 !xferDoneIrq)
        else $error("Disable raised the completion pulse.");
    gapStall_a: assert property ((state_reg == ST_GAP) && cpuRamReq
        && serialMode_reg.ifaceEnable |=> $stable(gapCnt_reg))
        else $error("Interval advanced during a CPU buffer access.");

    blockDone_c: cover property (doneSet && lastByte);
    repeatWrap_c: cover property ((state_reg == ST_STORE) && lastByte
        && serialMode_reg.repeatMode ##1 state_reg == ST_GAP);
    suspended_c: cover property (suspendPending_reg && $fell(busy_reg));
endmodule : auto_buffer_serial_transfer

// file: rtl/auto_xfer_pkg.sv
// Purpose: Shared constants, types and helpers for the buffered serial engine.
// Assumes: Wishbone classic slave, 32-bit data, byte address on wbAdr.
// Notes: Register words are aligned; narrow fields sit in the low bits.
package auto_xfer_pkg;

    // Bus and buffer geometry.
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int BYTE_W = 8;
    localparam int RAM_DEPTH = 32;
    localparam int RAM_AW = 5;

    // Register byte offsets.
    localparam logic [ADR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADR_W-1:0] OFS_TRIGGER = 8'h08;
    localparam logic [ADR_W-1:0] OFS_END_PTR = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_ADDR_CNT = 8'h10;
    localparam logic [ADR_W-1:0] OFS_INTERVAL = 8'h14;

    // Buffer RAM window: address bit 7 set, word index in bits 6..2.
    localparam int RAM_SEL_BIT = 7;
    localparam int RAM_IDX_LSB = 2;

    // Field positions in the trigger and status words.
    localparam int TRIG_START_BIT = 0;
    localparam int TRIG_SUSPEND_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;

    // Reset values.
    localparam logic [BYTE_W-1:0] MODE_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] INTERVAL_RESET = 8'h00;
    localparam logic [RAM_AW-1:0] ADDR_RESET = 5'h00;

    // Bits in one transfer unit.
    localparam logic [3:0] BITS_PER_UNIT = 4'h8;

    // Mode register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic ifaceEnable;
        logic autoModeEnable;
        logic repeatMode;
        logic masterSel;
        logic txEnable;
        logic rxEnable;
        logic bitOrderLsb;
        logic spare;
    } serial_mode_t;

    // Engine states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_SHIFT,
        ST_STORE,
        ST_GAP
    } xfer_state_t;

    // Bit that leaves the shifter next, for either bit order.
    function automatic logic outBit(input logic [BYTE_W-1:0] d,
                                    input logic lsbFirst);
        outBit = lsbFirst ? d[0] : d[BYTE_W-1];
    endfunction : outBit

    // Shifter value after one bit is taken in.
    function automatic logic [BYTE_W-1:0] shiftIn(
        input logic [BYTE_W-1:0] d, input logic lsbFirst, input logic b);
        shiftIn = lsbFirst ? {b, d[BYTE_W-1:1]} : {d[BYTE_W-2:0], b};
    endfunction : shiftIn

endpackage : auto_xfer_pkg

// file: verification/serial_partner.sv
// Purpose: Behavioural far-side device that clocks the serial link.
// Assumes: The link clock idles high and stands still between bytes.
// Notes: Half period 100 ns; the lead-in keeps edges off the core grid.
`timescale 1ns/1ps
module serial_partner (
    // Link pins as seen from the far side.
    output logic serialClockPin,
    input wire logic serialOutPin,
    output logic serialInPin
);
    // The clock idles high and the data line starts low.
    initial begin
        serialClockPin = 1'b1;
        serialInPin = 1'b0;
    end

    // One whole byte: data changes on the falling edge and the reply is
    // taken late in the high phase. The lead-in covers the load and gap,
    // because the engine ignores edges outside its shift phase.
    task automatic xfer_byte(input logic [7:0] tx, input logic lsb,
                             output logic [7:0] rx);
        int i;
        rx = 8'h00;
        #407;
        for (i = 0; i < 8; i++) begin
            serialClockPin = 1'b0;
            serialInPin = tx[lsb ? i : 7 - i];
            #100;
            serialClockPin = 1'b1;
            #90;
            rx[lsb ? i : 7 - i] = serialOutPin;
            #10;
        end
        // Past its hold time the line no longer shows the last bit.
        serialInPin = ~serialInPin;
    endtask : xfer_byte
endmodule : serial_partner

// file: verification/tb_auto_buffer_serial_transfer.sv
// Purpose: Self-checking bench for the buffered serial transfer engine.
// Assumes: The partner model clocks the link; registers go over Wishbone.
// Notes: Halt is raised once, holding a transfer before its first bit.
`timescale 1ns/1ps
module tb_auto_buffer_serial_transfer;
    import auto_xfer_pkg::*;
    // Design inputs, each given a value at time zero.
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [3:0] wbSel = 4'h0;
    logic [ADR_W-1:0] wbAdr = 8'h00;
    logic [DAT_W-1:0] wbDatIn = 32'h00000000;
    logic cpuHalt = 1'b0;
    // Design outputs and link wires.
    logic [DAT_W-1:0] wbDatOut;
    logic wbAck;
    logic serialClockPin;
    logic serialInPin;
    logic serialOutPin;
    logic serialOutOe;
    logic portPinAltRelease;
    logic xferDoneIrq;
    logic xferInProgress;
    // Bookkeeping and test data.
    int n_mismatch = 0;
    int n_tests = 0;
    int irqSeen = 0;
    int k;
    logic [BYTE_W-1:0] txData [0:2] = '{8'h96, 8'h5A, 8'hC3};
    logic [BYTE_W-1:0] rxData [0:2] = '{8'h3C, 8'hA5, 8'h0F};

    always #12.5 core_clk = ~core_clk;

    // Completion pulses are counted so silent endings can be told apart.
    always @(posedge core_clk) begin
        if (xferDoneIrq === 1'b1) begin
            irqSeen <= irqSeen + 1;
        end
    end

    auto_buffer_serial_transfer auto_buffer_serial_transfer_i (
        .core_clk(core_clk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr), .wbDatIn(wbDatIn),
        .wbDatOut(wbDatOut), .wbAck(wbAck), .serialClockPin(serialClockPin),
        .serialInPin(serialInPin), .serialOutPin(serialOutPin),
        .serialOutOe(serialOutOe), .portPinAltRelease(portPinAltRelease),
        .cpuHalt(cpuHalt), .xferDoneIrq(xferDoneIrq),
        .xferInProgress(xferInProgress));

    serial_partner serial_partner_i (.serialClockPin(serialClockPin),
        .serialOutPin(serialOutPin), .serialInPin(serialInPin));

    // Compares one value with case inequality so unknowns never match.
    task automatic chk(input logic [DAT_W-1:0] act,
                       input logic [DAT_W-1:0] exp);
        n_tests++;
        if (act !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask : chk

    // One classic cycle; everything holds until the edge that sees ack.
    task automatic wb_cycle(input logic we, input logic [ADR_W-1:0] a,
        input logic [DAT_W-1:0] d, output logic [DAT_W-1:0] q);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'hF;
        wbAdr <= a;
        wbDatIn <= d;
        // Only the watchdog ends a wait for an answer that never comes.
        do begin
            @(posedge core_clk);
        end while (wbAck !== 1'b1);
        q = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask : wb_cycle

    task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
        logic [DAT_W-1:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [ADR_W-1:0] a,
                         input logic [DAT_W-1:0] exp);
        logic [DAT_W-1:0] q;
        wb_cycle(1'b0, a, 32'h00000000, q);
        chk(q, exp);
    endtask : rdchk

    // Lets the partner clock one byte and checks what the engine sent.
    task automatic link(input logic [7:0] tx, input logic lsb,
                        input logic [7:0] exp);
        logic [7:0] got;
        serial_partner_i.xfer_byte(tx, lsb, got);
        chk({24'h000000, got}, {24'h000000, exp});
    endtask : link

    // Bounded wait for the busy status to drop.
    task automatic wait_idle();
        int i;
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk);
            if (xferInProgress === 1'b0) break;
        end
        // A transfer that never ends counts against the run.
        if (i == 100) n_mismatch++;
        // One more edge lets the pulse counter catch up.
        @(posedge core_clk);
    endtask : wait_idle

    task automatic final_report();
        $display("Checks: %0d, mismatches: %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // Nine bytes take well under a millisecond.
    initial begin
        #1000000;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        chk({26'h0000000, wbAck, xferInProgress, xferDoneIrq, serialOutOe,
            portPinAltRelease, serialOutPin}, 32'h00000003);
        rdchk(OFS_INTERVAL, 32'h00000000);
        rdchk(8'h40, 32'h00000000);
        for (k = 0; k < 3; k++) begin
            wr(8'h80 + 8'(4 * k), {24'h000000, txData[k]});
        end
        wr(OFS_END_PTR, 32'h00000002);
        wr(OFS_INTERVAL, 32'h00000002);
        // Start with neither direction enabled must be refused.
        wr(OFS_MODE, 32'h000000C0);
        wr(OFS_TRIGGER, 32'h00000001);
        rdchk(OFS_STATUS, 32'h00000000);
        // Transmit and receive, most significant bit first.
        wr(OFS_MODE, 32'h000000CC);
        wr(OFS_TRIGGER, 32'h00000001);
        chk({29'h00000000, xferInProgress, serialOutOe, portPinAltRelease},
            32'h00000006);
        for (k = 0; k < 3; k++) begin
            link(rxData[k], 1'b0, txData[k]);
        end
        wait_idle();
        rdchk(OFS_STATUS, 32'h00000002);
        rdchk(OFS_ADDR_CNT, 32'h00000000);
        chk(32'(irqSeen), 32'h00000001);
        for (k = 0; k < 3; k++) begin
            rdchk(8'h80 + 8'(4 * k), {24'h000000, rxData[k]});
        end
        wr(OFS_STATUS, 32'h00000002);
        // Transmit only, least significant bit first, two bytes.
        wr(OFS_END_PTR, 32'h00000001);
        wr(OFS_MODE, 32'h000000CA);
        @(posedge core_clk);
        chk({31'h00000000, portPinAltRelease}, 32'h00000001);
        // Halt holds the engine before its first bit; the old bit stays.
        cpuHalt <= 1'b1;
        wr(OFS_TRIGGER, 32'h00000001);
        repeat (8) @(posedge core_clk);
        chk({30'h00000000, xferInProgress, serialOutPin}, 32'h3);
        cpuHalt <= 1'b0;
        link(8'hFF, 1'b1, rxData[0]);
        link(8'hFF, 1'b1, rxData[1]);
        wait_idle();
        chk({31'h00000000, xferInProgress}, 32'h00000000);
        chk(32'(irqSeen), 32'h00000002);
        rdchk(8'h80, {24'h000000, rxData[0]});
        // Repeat mode wraps silently, then a suspend lands mid-byte.
        wr(OFS_MODE, 32'h000000E8);
        wr(OFS_TRIGGER, 32'h00000001);
        link(8'h00, 1'b0, rxData[0]);
        link(8'h00, 1'b0, rxData[1]);
        // A buffer read during the gap must stretch the interval.
        rdchk(8'h84, {24'h000000, rxData[1]});
        link(8'h00, 1'b0, rxData[0]);
        rdchk(OFS_ADDR_CNT, 32'h00000001);
        chk(32'(irqSeen), 32'h00000002);
        fork
            link(8'h00, 1'b0, rxData[1]);
            begin
                #900;
                wr(OFS_TRIGGER, 32'h00000002);
                chk({31'h00000000, xferInProgress}, 32'h00000001);
            end
        join
        wait_idle();
        chk({31'h00000000, xferInProgress}, 32'h00000000);
        chk(32'(irqSeen), 32'h00000003);
        // Clearing the enable mid-run ends the transfer without a pulse.
        wr(OFS_END_PTR, 32'h00000003);
        wr(OFS_MODE, 32'h000000C8);
        wr(OFS_TRIGGER, 32'h00000001);
        wr(OFS_MODE, 32'h00000000);
        @(posedge core_clk);
        chk({30'h00000000, xferInProgress, serialOutOe}, 32'h0);
        rdchk(OFS_ADDR_CNT, 32'h00000000);
        chk(32'(irqSeen), 32'h00000003);
        final_report();
    end
endmodule : tb_auto_buffer_serial_transfer
